/* File: pkg/dep_pkg.sv */
// Package: constants for the DRAM ECC/parity checker
package dep_pkg;
	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [7:0] CTRL_OFF   = 8'h00;
	localparam logic [7:0] TEST_OFF   = 8'h04;
	localparam logic [7:0] STAT_OFF   = 8'h08;
	localparam logic [7:0] MASK_OFF   = 8'h0C;
	localparam logic [7:0] SYND_OFF   = 8'h10;
	localparam logic [7:0] ADDR_OFF   = 8'h14;
	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int CTRL_ECC_BIT  = 0;
	localparam int CTRL_TEST_BIT = 1;
	localparam int STAT_SBE_BIT  = 0;
	localparam int STAT_MBE_BIT  = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [7:0] TEST_RESET = 8'h00;
	localparam logic [1:0] MASK_RESET = 2'h0;
	// ************************************************************
	// Timing: extra read latency with ECC, in host clock cycles
	// ************************************************************
	localparam int ECC_EXTRA_CYC = 1;
	// ************************************************************
	// Access sequencer states
	// ************************************************************
	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_RDW   = 5'b00010,
		ST_CHK   = 5'b00100,
		ST_MRGW  = 5'b01000,
		ST_DONE  = 5'b10000
	} dep_state_t;
endpackage

/* File: src/dep_ecc_code.sv */
// Check-bit generator: SEC-DED code with nibble detection, or byte parity
`timescale 1ns/10ps
module dep_ecc_code (
	input  wire logic [63:0] data,
	input  wire logic        eccMode,
	output logic      [7:0]  check
);
	// Even-weight half for one column
	function automatic logic [3:0] evenPat(input int k);
		case (k % 4)
			0:       return 4'hF;
			1:       return 4'hC;
			2:       return 4'hA;
			default: return 4'h6;
		endcase
	endfunction

	// Column code for bit i: one half odd, one half even, so every
	// column has odd weight, and any multi-bit error inside one nibble leaves a
	// syndrome that is no column and cannot be miscorrected
	function automatic logic [7:0] colCode(input int i);
		int         n;
		int         j;
		logic [3:0] evenHalf;
		logic [3:0] oddHalf;
		n = (i / 4) % 8;
		j = i % 4;
		if (n < 4) begin
			evenHalf = evenPat(j + n);
			oddHalf  = 4'h1 << j;
		end else begin
			evenHalf = evenPat(j);
			oddHalf  = ~(4'h1 << (n - 4));
		end
		// Upper data half mirrors the code into the other check half
		if (i < 32) begin
			return {evenHalf, oddHalf};
		end
		return {oddHalf, evenHalf};
	endfunction

	always_comb begin
		check = 8'h00;
		if (eccMode) begin
			for (int i = 0; i < 64; i++) begin
				if (data[i]) begin
					check = check ^ colCode(i);
				end
			end
		end else begin
			for (int b = 0; b < 8; b++) begin
				check[b] = ^data[8*b +: 8];
			end
		end
	end
endmodule

/* File: src/dep_ecc_fix.sv */
// Syndrome decode and single-bit correction
`timescale 1ns/10ps
module dep_ecc_fix (
	input  wire logic [63:0] data,
	input  wire logic [7:0]  syndrome,
	input  wire logic        eccMode,
	output logic      [63:0] fixed,
	output logic             sbe,
	output logic             mbe
);
	// Must match the generator's column table bit for bit
	function automatic logic [3:0] evenPat(input int k);
		case (k % 4)
			0:       return 4'hF;
			1:       return 4'hC;
			2:       return 4'hA;
			default: return 4'h6;
		endcase
	endfunction

	function automatic logic [7:0] colCode(input int i);
		int         n;
		int         j;
		logic [3:0] evenHalf;
		logic [3:0] oddHalf;
		n = (i / 4) % 8;
		j = i % 4;
		if (n < 4) begin
			evenHalf = evenPat(j + n);
			oddHalf  = 4'h1 << j;
		end else begin
			evenHalf = evenPat(j);
			oddHalf  = ~(4'h1 << (n - 4));
		end
		if (i < 32) begin
			return {evenHalf, oddHalf};
		end
		return {oddHalf, evenHalf};
	endfunction

	always_comb begin
		logic hit;
		hit   = 1'b0;
		fixed = data;
		sbe   = 1'b0;
		mbe   = 1'b0;
		if (!eccMode) begin
			// Parity cannot correct; any mismatch is uncorrectable
			mbe = (syndrome != 8'h00);
		end else if (syndrome != 8'h00) begin
			for (int i = 0; i < 64; i++) begin
				if (syndrome == colCode(i)) begin
					fixed[i] = ~data[i];
					hit      = 1'b1;
				end
			end
			// Check-bit error: single weight-one syndrome
			if ($countones(syndrome) == 1) begin
				hit = 1'b1;
			end
			sbe = hit;
			mbe = !hit;
		end
	end
endmodule

/* File: src/dep_checker.sv */
// Top: DRAM data-integrity checker with AHB-Lite register slave
//
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
// Function
// - With ECC on, every memory write carries eight check bits over 64 bits.
// - A partial write is done as read, byte merge, then full write.
// - ECC reads flag single, double and single-nibble multi-bit errors.
// - Single-bit errors are corrected and handed to the requester.
// - The corrected word is never written back after a read.
// - Error status stays set until software clears it.
// - In test mode writes store the software check value instead.
// - ECC adds exactly one host clock to read leadoff latency.
// - With the ECC enable bit zero, even parity is used instead.
// - Parity mode adds no cycles to any access.
module dep_checker #(
	parameter int ADDR_W = 32
) (
	input  wire logic              clock,
	input  wire logic              rst_n,
	// AHB-Lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic              hready,
	input  wire logic [31:0]       hwdata,
	output logic      [31:0]       hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic                   irq,
	// Requester side
	input  wire logic              reqValid,
	input  wire logic              reqWrite,
	input  wire logic [ADDR_W-1:0] reqAddr,
	input  wire logic [63:0]       reqWdata,
	input  wire logic [7:0]        reqBe,
	output logic                   reqDone,
	output logic      [63:0]       reqRdata,
	output logic                   reqErr,
	// Memory side, 72 bits
	output logic                   memReq,
	output logic                   memWrite,
	output logic      [ADDR_W-1:0] memAddr,
	output logic      [63:0]       memWdata,
	output logic      [7:0]        memWcheck,
	input  wire logic              memAck,
	input  wire logic [63:0]       memRdata,
	input  wire logic [7:0]        memRcheck
);
	initial begin
		if (ADDR_W < 1 || ADDR_W > 32) begin
			$error("ADDR_W must be 1..32");
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	logic [1:0]        ctrl_reg;
	logic [7:0]        testCheck_reg;
	logic [1:0]        stat_reg;
	logic [1:0]        mask_reg;
	logic [7:0]        synd_reg;
	logic [ADDR_W-1:0] errAddr_reg;
	dep_pkg::dep_state_t state_reg;
	dep_pkg::dep_state_t state_next;
	logic [63:0]       rdData_reg;
	logic [7:0]        rdCheck_reg;
	logic              wasRead_reg;
	logic              busWr_reg;
	logic              busRd_reg;
	logic [7:0]        busAddr_reg;

	logic              eccOn;
	logic              testOn;
	logic [63:0]       genData;
	logic [7:0]        genCheck;
	logic [7:0]        readCheck;
	logic [63:0]       fixData;
	logic              sbeNow;
	logic              mbeNow;
	logic [63:0]       mergeData;
	logic [7:0]        chkSyn;
	logic              errEvent;
	logic              fullWrite;

	assign eccOn     = ctrl_reg[dep_pkg::CTRL_ECC_BIT];
	assign testOn    = ctrl_reg[dep_pkg::CTRL_TEST_BIT];
	assign fullWrite = (reqBe == 8'hFF);

	function automatic logic [63:0] mergeBytes(input logic [63:0] oldW,
		input logic [63:0] newW, input logic [7:0] be);
		logic [63:0] m;
		m = oldW;
		for (int b = 0; b < 8; b++) begin
			if (be[b]) begin
				m[8*b +: 8] = newW[8*b +: 8];
			end
		end
		return m;
	endfunction

	// ************************************************************
	// Code generation and checking
	// ************************************************************
	// merge new bytes
	assign mergeData = mergeBytes(rdData_reg, reqWdata, reqBe);
	// Merged word is coded in the check cycle, where its write is issued
	assign genData   = (state_reg == dep_pkg::ST_CHK) ? mergeData : reqWdata;

	dep_ecc_code uGen (
		.data    (genData),
		.eccMode (eccOn),
		.check   (genCheck)
	);

	// Check bits recomputed from the word just read
	dep_ecc_code uRdGen (
		.data    (eccOn ? rdData_reg : memRdata),
		.eccMode (eccOn),
		.check   (readCheck)
	);

	// parity checks the live word; ECC checks the held word
	assign chkSyn = eccOn ? (readCheck ^ rdCheck_reg) : (readCheck ^ memRcheck);

	dep_ecc_fix uFix (
		.data     (eccOn ? rdData_reg : memRdata),
		.syndrome (chkSyn),
		.eccMode  (eccOn),
		.fixed    (fixData),
		.sbe      (sbeNow),
		.mbe      (mbeNow)
	);

	// ************************************************************
	// Access sequencer
	// ************************************************************
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			dep_pkg::ST_IDLE: begin
				if (reqValid) begin
					state_next = dep_pkg::ST_RDW;
				end
			end
			dep_pkg::ST_RDW: begin
				if (memAck) begin
					if (wasRead_reg && !eccOn) begin
						state_next = dep_pkg::ST_DONE;
					end else if (wasRead_reg || !memWrite) begin
						state_next = dep_pkg::ST_CHK;
					end else begin
						state_next = dep_pkg::ST_DONE;
					end
				end
			end
			dep_pkg::ST_CHK: begin
				if (wasRead_reg) begin
					state_next = dep_pkg::ST_DONE;
				end else begin
					state_next = dep_pkg::ST_MRGW;
				end
			end
			dep_pkg::ST_MRGW: begin
				if (memAck) begin
					state_next = dep_pkg::ST_DONE;
				end
			end
			dep_pkg::ST_DONE: begin
				state_next = dep_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_reg <= dep_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Memory command; the read of a partial write is a plain read
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			memReq      <= 1'b0;
			memWrite    <= 1'b0;
			memAddr     <= '0;
			memWdata    <= 64'h0;
			memWcheck   <= 8'h00;
			wasRead_reg <= 1'b0;
		end else begin
			if (state_reg == dep_pkg::ST_IDLE && reqValid) begin
				memReq      <= 1'b1;
				memAddr     <= reqAddr;
				wasRead_reg <= !reqWrite;
				memWrite    <= reqWrite && fullWrite;
				memWdata    <= reqWdata;
				// forced check value in test mode
				memWcheck   <= testOn ? testCheck_reg : genCheck;
			end else if (state_reg == dep_pkg::ST_CHK && !wasRead_reg) begin
				memReq    <= 1'b1;
				memWrite  <= 1'b1;
				// write merged word with fresh check
				memWdata  <= mergeData;
				memWcheck <= testOn ? testCheck_reg : genCheck;
			end else if (memAck) begin
				memReq <= 1'b0;
			end
		end
	end

	// Read capture: ECC holds the word one cycle for decoding
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdData_reg  <= 64'h0;
			rdCheck_reg <= 8'h00;
		end else if (state_reg == dep_pkg::ST_RDW && memAck) begin
			rdData_reg  <= memRdata;
			rdCheck_reg <= memRcheck;
		end
	end

	// ECC result one cycle after the data; corrected to requester
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			reqDone  <= 1'b0;
			reqRdata <= 64'h0;
			reqErr   <= 1'b0;
		end else begin
			reqDone <= 1'b0;
			if (state_reg == dep_pkg::ST_RDW && memAck && wasRead_reg && !eccOn) begin
				reqDone  <= 1'b1;
				reqRdata <= memRdata;
				reqErr   <= mbeNow;
			end else if (state_reg == dep_pkg::ST_CHK && wasRead_reg) begin
				reqDone  <= 1'b1;
				reqRdata <= fixData;
				reqErr   <= mbeNow;
			end else if ((state_reg == dep_pkg::ST_RDW && memAck && !wasRead_reg
				&& memWrite) || (state_reg == dep_pkg::ST_MRGW && memAck)) begin
				reqDone <= 1'b1;
				reqErr  <= 1'b0;
			end
		end
	end

	// Checks happen where read data is judged
	assign errEvent = ((state_reg == dep_pkg::ST_CHK) && eccOn)
		|| ((state_reg == dep_pkg::ST_RDW) && memAck && wasRead_reg && !eccOn);

	// ************************************************************
	// Error status, sticky; set wins over clear
	// ************************************************************
	logic       wrStat;
	logic [1:0] setBits;
	assign wrStat  = busWr_reg && busAddr_reg == dep_pkg::STAT_OFF;
	assign setBits = errEvent ? {mbeNow, sbeNow} : 2'b00;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			stat_reg    <= 2'b00;
			synd_reg    <= 8'h00;
			errAddr_reg <= '0;
		end else begin
			stat_reg <= (stat_reg & ~(wrStat ? hwdata[1:0] : 2'b00)) | setBits;
			if (setBits != 2'b00) begin
				synd_reg    <= chkSyn;
				errAddr_reg <= memAddr;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(stat_reg & mask_reg);
		end
	end

	// ************************************************************
	// AHB-Lite slave, zero wait states
	// ************************************************************
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			busWr_reg   <= 1'b0;
			busRd_reg   <= 1'b0;
			busAddr_reg <= 8'h00;
		end else if (hready) begin
			busWr_reg   <= hsel && htrans[1] && hwrite;
			busRd_reg   <= hsel && htrans[1] && !hwrite;
			busAddr_reg <= haddr[7:0];
		end
	end

	// ECC enable bit selects ECC or parity
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctrl_reg      <= dep_pkg::CTRL_RESET;
			testCheck_reg <= dep_pkg::TEST_RESET;
			mask_reg      <= dep_pkg::MASK_RESET;
		end else if (busWr_reg) begin
			if (busAddr_reg == dep_pkg::CTRL_OFF) begin
				ctrl_reg <= hwdata[1:0];
			end
			if (busAddr_reg == dep_pkg::TEST_OFF) begin
				testCheck_reg <= hwdata[7:0];
			end
			if (busAddr_reg == dep_pkg::MASK_OFF) begin
				mask_reg <= hwdata[1:0];
			end
		end
	end

	logic [31:0] rdMux;
	always_comb begin
		rdMux = 32'h0;
		unique case (haddr[7:0])
			dep_pkg::CTRL_OFF: rdMux = {30'h0, ctrl_reg};
			dep_pkg::TEST_OFF: rdMux = {24'h0, testCheck_reg};
			dep_pkg::STAT_OFF: rdMux = {30'h0, stat_reg};
			dep_pkg::MASK_OFF: rdMux = {30'h0, mask_reg};
			dep_pkg::SYND_OFF: rdMux = {24'h0, synd_reg};
			dep_pkg::ADDR_OFF: rdMux = 32'(errAddr_reg);
			default:           rdMux = 32'h0;
		endcase
	end

	// Read data registered from the address phase
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			hrdata    <= 32'h0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (hready && hsel && htrans[1] && !hwrite) begin
				hrdata <= rdMux;
			end
		end
	end
endmodule

/* File: tb/dep_checker_sva.sv */
// Checker: port-level properties of the integrity block
`timescale 1ns/10ps
module dep_checker_sva #(
	parameter int ADDR_W = 32
) (
	input wire logic              clock,
	input wire logic              rst_n,
	input wire logic              hsel,
	input wire logic [1:0]        htrans,
	input wire logic              hwrite,
	input wire logic              hready,
	input wire logic              hreadyout,
	input wire logic              hresp,
	input wire logic              irq,
	input wire logic              reqValid,
	input wire logic              reqWrite,
	input wire logic [7:0]        reqBe,
	input wire logic              reqDone,
	input wire logic              memReq,
	input wire logic              memWrite,
	input wire logic [ADDR_W-1:0] memAddr,
	input wire logic [7:0]        memWcheck,
	input wire logic              memAck
);
	logic dataPh;
	logic rdSeen;
	always_ff @(posedge clock) begin
		if (!rst_n)
			dataPh <= 1'b0;
		else
			dataPh <= hsel && hready && htrans[1] && hwrite;
	end
	always_ff @(posedge clock) begin
		if (!rst_n || reqDone)
			rdSeen <= 1'b0;
		else if (memAck && !memWrite)
			rdSeen <= 1'b1;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("register bus not ready or not okay");
	a_req_held: assert property (memReq && !memAck |=>
		memReq && $stable(memAddr) && $stable(memWcheck))
		else $error("memory request changed before ack");
	a_full_write: assert property (
		memReq && reqValid && reqWrite && reqBe == 8'hFF |-> memWrite)
		else $error("full write not issued as write");
	a_rmw_order: assert property (
		$rose(memReq) && memWrite && reqBe != 8'hFF |-> rdSeen)
		else $error("partial write without prior read");
	a_no_wback: assert property (
		memReq && reqValid && !reqWrite |-> !memWrite)
		else $error("memory written during a read");
	a_wr_cause: assert property (
		$rose(memReq) && memWrite |-> reqValid && reqWrite)
		else $error("memory write without write request");
	a_done_pulse: assert property (reqDone |=> !reqDone)
		else $error("done longer than one cycle");
	a_done_lat: assert property (reqDone |->
		$past(memAck, 1) || $past(memAck, 2) || $past(memAck, 3))
		else $error("done not shortly after memory ack");
	a_irq_hold: assert property ($fell(irq) |->
		$past(dataPh, 1) || $past(dataPh, 2) || $past(dataPh, 3))
		else $error("interrupt dropped without register write");
endmodule
bind dep_checker dep_checker_sva #(.ADDR_W(ADDR_W)) u_sva (
	.clock(clock), .rst_n(rst_n), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .irq(irq), .reqValid(reqValid), .reqWrite(reqWrite),
	.reqBe(reqBe), .reqDone(reqDone), .memReq(memReq),
	.memWrite(memWrite), .memAddr(memAddr), .memWcheck(memWcheck),
	.memAck(memAck)
);

/* File: tb/dep_dram_model.sv */
// DRAM module model: 72-bit word store with variable ack delay
`timescale 1ns/10ps
module dep_dram_model #(
	parameter int ADDR_W = 32
) (
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic              memReq,
	input  wire logic              memWrite,
	input  wire logic [ADDR_W-1:0] memAddr,
	input  wire logic [63:0]       memWdata,
	input  wire logic [7:0]        memWcheck,
	input  wire logic              slow,
	output logic                   memAck,
	output logic      [63:0]       memRdata,
	output logic      [7:0]        memRcheck
);
	logic [71:0] store [logic [ADDR_W-1:0]];
	logic [71:0] nxt;
	logic        armed;
	logic        ackN;
	int          wt;
	initial begin
		memAck = 1'b0;
		{memRcheck, memRdata} = 72'h0;
		armed = 1'b1;
		wt = 0;
		forever begin
			@(posedge clock);
			// Released bus toggles so stale data never looks valid
			nxt = ~{memRcheck, memRdata};
			ackN = 1'b0;
			if (!memReq || !rst_n) begin
				armed = 1'b1;
				wt = slow ? $urandom_range(5) : 0;
			end else if (armed && wt > 0) begin
				wt--;
			end else if (armed) begin
				armed = 1'b0;
				ackN = 1'b1;
				if (memWrite)
					store[memAddr] = {memWcheck, memWdata};
				else
					nxt = store[memAddr];
			end
			memAck <= ackN;
			{memRcheck, memRdata} <= nxt;
		end
	end
endmodule

/* File: tb/testbench.sv */
// Testbench: random and corner tests of the integrity checker
`timescale 1ns/10ps
module testbench;
	logic        clock, rst_n, hsel, hwrite, hready, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, rd, reqAddr, memAddr, a;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        reqValid, reqWrite, reqDone, reqErr, err, slow, sb;
	logic        memReq, memWrite, memAck;
	logic [63:0] reqWdata, reqRdata, memWdata, memRdata, d, n, r;
	logic [7:0]  reqBe, memWcheck, memRcheck, be;
	logic [71:0] flip, s;
	int          n_mismatch, n_checks, lat, latW, p;

	assign hready = hreadyout;
	dep_checker DUT (.clock, .rst_n, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .irq,
		.reqValid, .reqWrite, .reqAddr, .reqWdata, .reqBe, .reqDone,
		.reqRdata, .reqErr, .memReq, .memWrite, .memAddr, .memWdata,
		.memWcheck, .memAck, .memRdata, .memRcheck);
	dep_dram_model u_dram (.clock, .rst_n, .memReq, .memWrite, .memAddr,
		.memWdata, .memWcheck, .slow, .memAck, .memRdata, .memRcheck);

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	function logic [7:0] par(input logic [63:0] v);
		for (int i = 0; i < 8; i++) par[i] = ^v[8*i +: 8];
	endfunction
	function logic [63:0] mrg(input logic [63:0] o, w, input logic [7:0] b);
		for (int i = 0; i < 8; i++) mrg[8*i +: 8] = b[i] ? w[8*i +: 8] : o[8*i +: 8];
	endfunction

	task chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
		n_checks++;
		if (got !== ex) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task tmo(input logic bad);
		if (bad) begin
			n_mismatch++;
			$display("Error wait expected handshake seen none");
			summarize();
		end
	endtask
	task bus(input logic [7:0] ad, input logic [31:0] wd, input logic wr);
		int k;
		hsel <= 1'b1;
		haddr <= {24'h0, ad};
		htrans <= 2'b10;
		hwrite <= wr;
		for (k = 0; k < 40; k++) begin
			@(posedge clock);
			if (hready === 1'b1) break;
		end
		tmo(k == 40);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		for (k = 0; k < 40; k++) begin
			@(posedge clock);
			if (hready === 1'b1) break;
		end
		tmo(k == 40);
		rd = hrdata;
	endtask
	task req(input logic w, input logic [63:0] wd, input logic [7:0] b);
		int k, ack;
		reqValid <= 1'b1;
		reqWrite <= w;
		reqAddr <= a;
		reqWdata <= wd;
		reqBe <= b;
		ack = 0;
		for (k = 0; k < 40; k++) begin
			@(posedge clock);
			if (memAck === 1'b1) ack = k;
			if (reqDone === 1'b1) break;
		end
		tmo(k == 40);
		lat = k - ack;
		r = reqRdata;
		err = reqErr;
		reqValid <= 1'b0;
		@(posedge clock);
	endtask
	task sts(input logic [31:0] ex);
		bus(dep_pkg::STAT_OFF, 32'h0, 1'b0);
		chk("status", ex, rd);
		chk("irq", ex != 0, irq);
		bus(dep_pkg::ADDR_OFF, 32'h0, 1'b0);
		if (ex != 0) chk("err addr", a, rd);
		bus(dep_pkg::STAT_OFF, 32'h3, 1'b1);
	endtask

	initial begin
		{hsel, hwrite, reqValid, reqWrite, slow, haddr, htrans} = '0;
		{hwdata, reqAddr, reqWdata, reqBe, a} = '0;
		hsize = 3'h2;
		n_mismatch = 0;
		n_checks = 0;
		rst_n = 1'b0;
		void'($urandom(32'hF2D740B4));
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		bus(dep_pkg::CTRL_OFF, 32'h0, 1'b0);
		chk("ctrl reset", dep_pkg::CTRL_RESET, rd);
		bus(8'h40, 32'h0, 1'b0);
		chk("unmapped", 64'h0, rd);
		bus(dep_pkg::MASK_OFF, 32'h3, 1'b1);
		for (int m = 0; m < 2; m++) begin
			bus(dep_pkg::CTRL_OFF, m, 1'b1);
			slow <= $urandom_range(1);
			a = $urandom & 32'hFFF8;
			d = {$urandom, $urandom};
			req(1'b1, d, 8'hFF);
			latW = lat;
			if (m == 0) chk("parity", par(d), u_dram.store[a][71:64]);
			req(1'b0, 64'h0, 8'h0);
			chk("clean data", d, r);
			chk("read latency", latW + m, lat);
			for (int f = 0; f < 4; f++) begin
				p = $urandom_range(63);
				case (f)
					0: flip = 72'h1 << p;
					1: flip = 72'h1 << (64 + p % 8);
					2: flip = (72'h1 << p) | (72'h1 << ((p + 8) % 64));
					default: flip = 72'hE << (4 * (p % 16));
				endcase
				s = u_dram.store[a];
				u_dram.store[a] = s ^ flip;
				req(1'b0, 64'h0, 8'h0);
				sb = m == 1 && f < 2;
				chk("read error", !sb, err);
				if (sb) chk("corrected", d, r);
				else if (m == 0) chk("raw data", d ^ flip[63:0], r);
				chk("kept word", s ^ flip, u_dram.store[a]);
				u_dram.store[a] = s;
				req(1'b0, 64'h0, 8'h0);
				sts(sb ? 32'h1 : 32'h2);
			end
			n = {$urandom, $urandom};
			be = $urandom;
			be[$urandom_range(7)] = 1'b0;
			req(1'b1, n, be);
			req(1'b0, 64'h0, 8'h0);
			chk("merged", mrg(d, n, be), r);
			if (m == 0) chk("merge parity", par(r), u_dram.store[a][71:64]);
			sts(32'h0);
			$display("mode %0d test done", m);
		end
		for (int t = 0; t < 2; t++) begin
			be = $urandom;
			bus(dep_pkg::TEST_OFF, {24'h0, be}, 1'b1);
			bus(dep_pkg::CTRL_OFF, 32'h2 | t, 1'b1);
			req(1'b1, {$urandom, $urandom}, 8'hFF);
			chk("forced check", be, u_dram.store[a][71:64]);
			$display("check override test %0d done", t);
		end
		summarize();
	end
endmodule
